// *** inc/vco_cfg_pkg.sv ***
`default_nettype none
package vco_cfg_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [6:0] ldo_and_core_a_amplitude_cfg_off   = 7'h2f;
  localparam logic [6:0] cal_stage_divider_off              = 7'h30;
  localparam logic [6:0] wait_count_low_off                 = 7'h31;
  localparam logic [6:0] converter_ctrl_wait_count_high_off = 7'h32;
  localparam logic [6:0] synthetic_lock_timeout_off         = 7'h33;
  localparam logic [6:0] amplitude_settle_timeout_off       = 7'h34;
  localparam logic [6:0] converter_clock_divider_off        = 7'h35;
  localparam logic [6:0] pump_current_offset_reserved_off   = 7'h36;
  localparam logic [6:0] test_band_select_off               = 7'h37;
  localparam logic [6:0] test_core_and_bias_select_off      = 7'h38;
  localparam int unsigned NUM_REGS = 10;

  // reset values
  localparam logic [7:0] ldo_and_core_a_amplitude_cfg_rst   = 8'h92;
  localparam logic [7:0] cal_stage_divider_rst              = 8'h3f;
  localparam logic [7:0] wait_count_low_rst                 = 8'ha7;
  localparam logic [7:0] converter_ctrl_wait_count_high_rst = 8'h04;
  localparam logic [7:0] synthetic_lock_timeout_rst         = 8'h0c;
  localparam logic [7:0] amplitude_settle_timeout_rst       = 8'h9e;
  localparam logic [7:0] converter_clock_divider_rst        = 8'h4c;
  localparam logic [7:0] pump_current_offset_reserved_rst   = 8'h30;
  localparam logic [7:0] test_band_select_rst               = 8'h00;
  localparam logic [7:0] test_core_and_bias_select_rst      = 8'h00;

  // writable-bit masks; zero bits are reserved and read as zero
  localparam logic [7:0] ldo_and_core_a_amplitude_cfg_msk   = 8'h9f;
  localparam logic [7:0] converter_ctrl_wait_count_high_msk = 8'hbf;
  localparam logic [7:0] synthetic_lock_timeout_msk         = 8'h1f;
  localparam logic [7:0] full_msk                           = 8'hff;

  // field positions
  localparam int unsigned ldo_supply_select_bit          = 7;
  localparam int unsigned core_a_rectifier_bias_sel_bit  = 4;
  localparam int unsigned core_a_low_threshold_range_bit = 3;
  localparam int unsigned converter_input_select_bit     = 7;
  localparam int unsigned converter_fast_mode_bit        = 5;
  localparam int unsigned converter_continuous_mode_bit  = 4;
  localparam int unsigned converter_start_bit            = 3;
  localparam int unsigned converter_power_bit            = 2;
  localparam int unsigned timeout_field_w                = 5;
  localparam int unsigned test_nibble_w                  = 4;
  localparam int unsigned wait_count_high_w              = 2;
  localparam int unsigned nominal_threshold_w            = 3;
endpackage
`default_nettype wire

// *** src/cfg_reg8.sv ***
`timescale 1ns/10ps
`default_nettype none
module cfg_reg8
  import vco_cfg_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // stored value
  output logic [7:0]      value_q
);
  // reserved bits never store, so they always read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      value_q <= RESET_VAL & WR_MASK;
    end else if (wr_en) begin
      value_q <= wr_data & WR_MASK;
    end
  end
endmodule
`default_nettype wire

// *** src/vco_cal_alc_adc_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// (RULE_01) ldo supply select bit7, reset one
// (RULE_02) core a rectifier bias bit4, reset one
// (RULE_03) core a low threshold range bit3
// (RULE_04) core a nominal threshold resets to 010
// (RULE_05) calibration stage divider, reset 0x3f
// (RULE_06) ten-bit wait count from two registers
// (RULE_07) converter input select bit7, reset zero
// (RULE_08) converter fast, continuous, start, power bits
// (RULE_09) five-bit synthetic lock wait, reset 0xc
// (RULE_10) five-bit amplitude settle wait, reset 0x1e
// (RULE_11) converter clock divider, reset 0x4c
// (RULE_12) test band select, reset zero
// (RULE_13) one-hot test core select field; the code stores any 4-bit value and does not check one-hot
// (RULE_14) test bias code field, reset zero
// (RULE_15) reserved read-only bits read zero
// (RULE_16) fields reset, hold and read back
module vco_cal_alc_adc_config_regs
  import vco_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  // register access from the serial control interface
  input  wire logic [ADDR_W-1:0]       reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [DATA_W-1:0]       reg_wdata,
  output logic [DATA_W-1:0]            reg_rdata_q,
  output logic                         reg_hit_q,
  // amplitude loop and supply controls
  output logic                         ldo_supply_select_q,
  output logic                         core_a_rectifier_bias_sel_q,
  output logic                         core_a_low_threshold_range_q,
  output logic [2:0]                   core_a_nominal_threshold_q,
  // calibration timing
  output logic [7:0]                   cal_stage_divider_q,
  output logic [9:0]                   wait_count_q,
  output logic [4:0]                   synthetic_lock_wait_q,
  output logic [4:0]                   amplitude_settle_wait_q,
  output logic [2:0]                   cal_fsm_test_field_q,
  // converter controls
  output logic                         converter_input_select_q,
  output logic                         converter_fast_mode_q,
  output logic                         converter_continuous_mode_q,
  output logic                         converter_start_q,
  output logic                         converter_power_q,
  output logic [7:0]                   converter_clock_divider_q,
  // test overrides and reserved trims
  output logic [7:0]                   pump_current_offset_q,
  output logic [7:0]                   test_band_select_q,
  output logic [3:0]                   test_core_select_q,
  output logic [3:0]                   test_bias_code_q
);

  localparam logic [6:0] OFFS [NUM_REGS] = '{
    ldo_and_core_a_amplitude_cfg_off, cal_stage_divider_off, wait_count_low_off,
    converter_ctrl_wait_count_high_off, synthetic_lock_timeout_off, amplitude_settle_timeout_off,
    converter_clock_divider_off, pump_current_offset_reserved_off, test_band_select_off,
    test_core_and_bias_select_off};
  localparam logic [7:0] RSTS [NUM_REGS] = '{
    ldo_and_core_a_amplitude_cfg_rst, cal_stage_divider_rst, wait_count_low_rst,
    converter_ctrl_wait_count_high_rst, synthetic_lock_timeout_rst, amplitude_settle_timeout_rst,
    converter_clock_divider_rst, pump_current_offset_reserved_rst, test_band_select_rst,
    test_core_and_bias_select_rst};
  localparam logic [7:0] MSKS [NUM_REGS] = '{
    ldo_and_core_a_amplitude_cfg_msk, full_msk, full_msk,
    converter_ctrl_wait_count_high_msk, synthetic_lock_timeout_msk, full_msk,
    full_msk, full_msk, full_msk, full_msk};

  logic [7:0]          regs [NUM_REGS];
  logic [NUM_REGS-1:0] sel;
  logic [7:0]          rd_mux;
  logic                hit;

  // (RULE_16) per-register storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign sel[gi] = (reg_addr == OFFS[gi]);
      // (RULE_15) masked reserved bits
      cfg_reg8 #(
        .RESET_VAL (RSTS[gi]),
        .WR_MASK   (MSKS[gi])
      ) u_reg (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .wr_en   (reg_wr & sel[gi]),
        .wr_data (reg_wdata),
        .value_q (regs[gi])
      );
    end
  endgenerate

  // (RULE_16) readback mux
  always_comb begin
    rd_mux = 8'h00;
    hit    = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (sel[i]) begin
        rd_mux = regs[i];
        hit    = 1'b1;
      end
    end
  end

  // readback registered; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 8'h00;
      reg_hit_q   <= 1'b0;
    end else begin
      reg_rdata_q <= rd_mux;
      reg_hit_q   <= hit;
    end
  end

  // field outputs, flopped so every output leaves a flip-flop
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ldo_supply_select_q          <= ldo_and_core_a_amplitude_cfg_rst[ldo_supply_select_bit];
      core_a_rectifier_bias_sel_q  <= ldo_and_core_a_amplitude_cfg_rst[core_a_rectifier_bias_sel_bit];
      core_a_low_threshold_range_q <= ldo_and_core_a_amplitude_cfg_rst[core_a_low_threshold_range_bit];
      core_a_nominal_threshold_q   <= ldo_and_core_a_amplitude_cfg_rst[nominal_threshold_w-1:0];
    end else begin
      // (RULE_01) supply choice
      ldo_supply_select_q          <= regs[0][ldo_supply_select_bit];
      // (RULE_02) rectifier bias
      core_a_rectifier_bias_sel_q  <= regs[0][core_a_rectifier_bias_sel_bit];
      // (RULE_03) threshold range
      core_a_low_threshold_range_q <= regs[0][core_a_low_threshold_range_bit];
      // (RULE_04) nominal threshold
      core_a_nominal_threshold_q   <= regs[0][nominal_threshold_w-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cal_stage_divider_q     <= cal_stage_divider_rst;
      wait_count_q            <= {converter_ctrl_wait_count_high_rst[wait_count_high_w-1:0], wait_count_low_rst};
      synthetic_lock_wait_q   <= synthetic_lock_timeout_rst[timeout_field_w-1:0];
      amplitude_settle_wait_q <= amplitude_settle_timeout_rst[timeout_field_w-1:0];
      cal_fsm_test_field_q    <= amplitude_settle_timeout_rst[DATA_W-1:timeout_field_w];
    end else begin
      // (RULE_05) stage time
      cal_stage_divider_q     <= regs[1];
      // (RULE_06) joined wait count
      wait_count_q            <= {regs[3][wait_count_high_w-1:0], regs[2]};
      // (RULE_09) lock wait field
      synthetic_lock_wait_q   <= regs[4][timeout_field_w-1:0];
      // (RULE_10) settle wait field
      amplitude_settle_wait_q <= regs[5][timeout_field_w-1:0];
      cal_fsm_test_field_q    <= regs[5][DATA_W-1:timeout_field_w];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      converter_input_select_q    <= converter_ctrl_wait_count_high_rst[converter_input_select_bit];
      converter_fast_mode_q       <= converter_ctrl_wait_count_high_rst[converter_fast_mode_bit];
      converter_continuous_mode_q <= converter_ctrl_wait_count_high_rst[converter_continuous_mode_bit];
      converter_start_q           <= converter_ctrl_wait_count_high_rst[converter_start_bit];
      converter_power_q           <= converter_ctrl_wait_count_high_rst[converter_power_bit];
      converter_clock_divider_q   <= converter_clock_divider_rst;
    end else begin
      // (RULE_07) converter input route
      converter_input_select_q    <= regs[3][converter_input_select_bit];
      // (RULE_08) converter mode bits
      converter_fast_mode_q       <= regs[3][converter_fast_mode_bit];
      converter_continuous_mode_q <= regs[3][converter_continuous_mode_bit];
      converter_start_q           <= regs[3][converter_start_bit];
      converter_power_q           <= regs[3][converter_power_bit];
      // (RULE_11) divider to clock generator
      converter_clock_divider_q   <= regs[6];
    end
  end

  // test overrides only matter when the calibration engine is in test mode
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pump_current_offset_q <= pump_current_offset_reserved_rst;
      test_band_select_q    <= test_band_select_rst;
      test_core_select_q    <= test_core_and_bias_select_rst[DATA_W-1:test_nibble_w];
      test_bias_code_q      <= test_core_and_bias_select_rst[test_nibble_w-1:0];
    end else begin
      pump_current_offset_q <= regs[7];
      // (RULE_12) band in core
      test_band_select_q    <= regs[8];
      // (RULE_13) core select nibble, passed through without a one-hot check
      test_core_select_q    <= regs[9][DATA_W-1:test_nibble_w];
      // (RULE_14) bias code
      test_bias_code_q      <= regs[9][test_nibble_w-1:0];
    end
  end

endmodule
`default_nettype wire

// *** tb/vco_cfg_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module vco_cfg_asserts
  import vco_cfg_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       nrst,
  // register access
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       reg_hit_q,
  // fields
  input wire logic       ldo_supply_select_q,
  input wire logic [2:0] core_a_nominal_threshold_q,
  input wire logic [7:0] cal_stage_divider_q,
  input wire logic [9:0] wait_count_q,
  input wire logic       converter_input_select_q,
  input wire logic       converter_power_q,
  input wire logic [3:0] test_core_select_q,
  input wire logic [3:0] test_bias_code_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic      [7:0] wd1_q;
  logic      [7:0] wd2_q;
  wire logic       mapped = reg_addr >= 7'h2f && reg_addr <= 7'h38;
  // fields settle two edges after the write, so the data is delayed to match
  always_ff @(posedge ref_clk) begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  sequence s_wr(logic [6:0] a);
    reg_wr && reg_addr == a;
  endsequence
  property p_unmapped; !mapped |=> reg_rdata_q == 8'h00 && !reg_hit_q; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hit; mapped |=> reg_hit_q; endproperty
  a_hit: assert property (p_hit) else $error("mapped read without hit");
  property p_rsvd; (reg_addr == 7'h2f || reg_addr == 7'h32) |=> reg_rdata_q[6] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit six set");
  property p_lock; reg_addr == 7'h33 |=> reg_rdata_q[7:5] == 3'b000; endproperty
  a_lock: assert property (p_lock) else $error("lock wait upper bits set");
  property p_ldo;
    s_wr(7'h2f) |=> ##1 {ldo_supply_select_q, core_a_nominal_threshold_q} == {wd2_q[7], wd2_q[2:0]};
  endproperty
  a_ldo: assert property (p_ldo) else $error("supply field wrong");
  property p_stage; s_wr(7'h30) |=> ##1 cal_stage_divider_q == wd2_q; endproperty
  a_stage: assert property (p_stage) else $error("stage divider wrong");
  property p_wait; s_wr(7'h31) |=> ##1 wait_count_q[7:0] == wd2_q; endproperty
  a_wait: assert property (p_wait) else $error("wait count low wrong");
  property p_conv;
    s_wr(7'h32) |=> ##1 {converter_input_select_q, converter_power_q, wait_count_q[9:8]} == {wd2_q[7], wd2_q[2:0]};
  endproperty
  a_conv: assert property (p_conv) else $error("converter field wrong");
  property p_test; s_wr(7'h38) |=> ##1 {test_core_select_q, test_bias_code_q} == wd2_q; endproperty
  a_test: assert property (p_test) else $error("test core or bias wrong");
  property p_hold; !reg_wr |=> ##1 $stable(cal_stage_divider_q) && $stable(wait_count_q); endproperty
  a_hold: assert property (p_hold) else $error("field moved without write");
endmodule
bind vco_cal_alc_adc_config_regs vco_cfg_asserts chk_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_hit_q(reg_hit_q),
  .ldo_supply_select_q(ldo_supply_select_q), .core_a_nominal_threshold_q(core_a_nominal_threshold_q),
  .cal_stage_divider_q(cal_stage_divider_q), .wait_count_q(wait_count_q),
  .converter_input_select_q(converter_input_select_q), .converter_power_q(converter_power_q),
  .test_core_select_q(test_core_select_q), .test_bias_code_q(test_bias_code_q));
`default_nettype wire

// *** tb/host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock and read data
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata_q,
  // request
  output var logic [6:0] reg_addr,
  output var logic       reg_wr,
  output var logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    // stale data inverted so it never looks like the last write
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    d = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// *** tb/vco_cal_alc_adc_config_regs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module vco_cal_alc_adc_config_regs_bench;
  import vco_cfg_pkg::*;
  logic       ref_clk, nrst, reg_wr, hit, ldo, rect, lo, cin, cf, cc, cs, cp;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, rdata, stage, cdiv, band, d, pco, wdat;
  logic [9:0] wcnt;
  logic [4:0] slw, asw;
  logic [3:0] core, bias;
  logic [2:0] nom, tfm;
  int         bad_count, comparisons;
  logic [7:0] rst_t [10] = '{8'h92, 8'h3f, 8'ha7, 8'h04, 8'h0c, 8'h9e, 8'h4c, 8'h30, 8'h00, 8'h00};
  logic [7:0] msk_t [10] = '{8'h9f, 8'hff, 8'hff, 8'hbf, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [3:0] codes [5]  = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  // host keeps the nominal code and reserved writable fields at reset value
  logic [7:0] keep_t [10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h00, 8'hff, 8'h00, 8'h00};
  host_model host_u (.ref_clk(ref_clk), .reg_rdata_q(rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  vco_cal_alc_adc_config_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .reg_hit_q(hit), .ldo_supply_select_q(ldo),
    .core_a_rectifier_bias_sel_q(rect), .core_a_low_threshold_range_q(lo), .core_a_nominal_threshold_q(nom),
    .cal_stage_divider_q(stage), .wait_count_q(wcnt), .synthetic_lock_wait_q(slw), .amplitude_settle_wait_q(asw),
    .cal_fsm_test_field_q(tfm), .converter_input_select_q(cin), .converter_fast_mode_q(cf),
    .converter_continuous_mode_q(cc), .converter_start_q(cs), .converter_power_q(cp),
    .converter_clock_divider_q(cdiv), .pump_current_offset_q(pco), .test_band_select_q(band),
    .test_core_select_q(core), .test_bias_code_q(bias));
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string n);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard; every wait below is a fixed count anyway
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 10; i++) begin
      host_u.rd(7'h2f + 7'(i), d);
      chk(d, rst_t[i], "reset value");
      chk(hit, 1'b1, "hit");
    end
    chk({ldo, rect, lo}, 3'b110, "supply bits");
    chk(nom, 3'b010, "nominal");
    chk(stage, 8'h3f, "stage div");
    chk(wcnt, 10'h0a7, "wait count");
    chk({cin, cf, cc, cs, cp}, 5'b00001, "conv ctrl");
    chk({slw, asw}, 10'h19e, "timeouts");
    chk(cdiv, 8'h4c, "conv clk div");
    chk({band, core, bias}, 16'h0000, "test regs");
    chk({tfm, pco}, 11'h430, "reserved writable");
    $display("reset test done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 10; i++) begin
        wdat = ((p ? 8'h00 : 8'hff) & ~keep_t[i]) | (rst_t[i] & keep_t[i]);
        host_u.wr(7'h2f + 7'(i), wdat);
        host_u.rd(7'h2f + 7'(i), d);
        chk(d, wdat & msk_t[i], "readback");
      end
      chk({ldo, rect, lo, nom, tfm, pco}, p ? 17'h01430 : 17'h1d430, "supply fields");
      chk({cf, cc, cs, asw, cdiv}, p ? 16'h0000 : 16'hffff, "conv fields");
      chk({band, slw}, p ? 13'h0000 : 13'h1fff, "band lock fields");
    end
    $display("readback test done");
    host_u.wr(7'h2e, 8'hff);
    host_u.wr(7'h39, 8'hff);
    host_u.rd(7'h39, d);
    chk({hit, d}, 9'h000, "unmapped");
    host_u.rd(7'h2f, d);
    chk(d, 8'h02, "neighbour");
    host_u.wr(7'h31, 8'h5a);
    host_u.wr(7'h32, 8'hed);
    host_u.rd(7'h32, d);
    chk(d, 8'had, "conv reg");
    chk(wcnt, 10'h15a, "wait count");
    chk({cin, cf, cc, cs, cp}, 5'b11011, "conv ctrl");
    $display("converter test done");
    for (int i = 0; i < 5; i++) begin
      host_u.wr(7'h38, {codes[i], ~codes[i]});
      @(negedge ref_clk);
      chk({core, bias}, {codes[i], ~codes[i]}, "core bias");
    end
    $display("test mode test done");
    summarize();
  end
endmodule
`default_nettype wire
